// [uart_sc_pkg.sv]
/*
  shared constants for the serial port status and control block: register
  offsets, field positions, reset values and bit timing.
  assumes a 250 MHz clock and a fixed bit period.
*/
package uart_sc_pkg;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  OFF_STATUS      = 4'h0;
  localparam logic [3:0]  OFF_MODE        = 4'h4;
  localparam logic [3:0]  OFF_TX_DATA     = 4'h8;
  localparam logic [3:0]  OFF_RX_DATA     = 4'hC;

  // ------------------------------------------------------------
  // status and control field positions
  // ------------------------------------------------------------
  localparam int unsigned POS_ADDR_DETECT_ENABLE      = 24;
  localparam int unsigned POS_MATCH_LO    = 16;
  localparam int unsigned POS_TXISEL_LO   = 14;
  localparam int unsigned POS_TX_INV      = 13;
  localparam int unsigned POS_RX_EN       = 12;
  localparam int unsigned POS_BREAK       = 11;
  localparam int unsigned POS_TX_EN       = 10;
  localparam int unsigned POS_TX_FULL     = 9;
  localparam int unsigned POS_SHIFT_EMPTY = 8;
  localparam int unsigned POS_RXISEL_LO   = 6;
  localparam int unsigned POS_ADDR_CHAR   = 5;
  localparam int unsigned POS_RX_IDLE     = 4;
  localparam int unsigned POS_PARITY_ERR  = 3;
  localparam int unsigned POS_FRAME_ERR   = 2;
  localparam int unsigned POS_OVERRUN     = 1;
  localparam int unsigned POS_RX_AVAIL    = 0;

  // mode register fields
  localparam int unsigned POS_MODE_ON     = 15;
  localparam int unsigned POS_MODE_IR     = 12;
  localparam int unsigned POS_MODE_PARITY = 1;

  // ------------------------------------------------------------
  // reset values and field codes
  // ------------------------------------------------------------
  localparam logic       RST_SHIFT_EMPTY  = 1'b1;
  localparam logic       RST_RX_IDLE      = 1'b1;
  localparam logic [1:0] TXI_NOT_FULL     = 2'h0;
  localparam logic [1:0] TXI_ALL_SENT     = 2'h1;
  localparam logic [1:0] TXI_EMPTY        = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned BIT_TIME_NS     = 64;
  localparam int unsigned BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned IR_PULSE_CYCLES = (BIT_CYCLES * 3) / 16;
  localparam int unsigned BREAK_ZEROS     = 12;
  localparam int unsigned CHAR_BITS       = 8;
  localparam int unsigned TX_DEPTH        = 4;

endpackage : uart_sc_pkg

// [tx_buffer.sv]
/*
  small transmit buffer memory with registered read data.
  a pop while empty and a push while full are ignored.
*/
`timescale 1ns/1ns
module tx_buffer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       flush,
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  input  wire logic       pop,
  // status and data
  output logic [7:0]      pop_data,
  output logic            full,
  output logic            empty
);
  logic [7:0] mem [uart_sc_pkg::TX_DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] count;
  wire        do_push = push && !full;
  wire        do_pop  = pop && !empty;

  assign full  = (count == 3'(uart_sc_pkg::TX_DEPTH));
  assign empty = (count == 3'h0);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= 2'h0;
      rd_ptr   <= 2'h0;
      count    <= 3'h0;
      pop_data <= 8'h00;
    end else if (flush) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (do_pop) begin
        rd_ptr   <= rd_ptr + 2'h1;
        pop_data <= mem[rd_ptr];
      end
      count <= count + 3'(do_push) - 3'(do_pop);
    end
  end
endmodule : tx_buffer

// [rx_engine.sv]
/*
  serial receiver: pin synchroniser, start detect, mid-bit sampling,
  optional even parity and stop check.
  assumes the pin is asynchronous; enable low holds it in idle.
*/
`timescale 1ns/1ns
module rx_engine (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       enable,
  input  wire logic       parity_on,
  input  wire logic       pin,
  // character out
  output logic            char_valid,
  output logic [7:0]      char_data,
  output logic            char_frame_err,
  output logic            char_parity_err,
  output logic            idle
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  localparam logic [4:0] HALF_BIT = 5'(uart_sc_pkg::BIT_CYCLES / 2 - 1);
  localparam logic [4:0] FULL_BIT = 5'(uart_sc_pkg::BIT_CYCLES - 1);

  rx_state_t  state;
  logic       pin_meta;
  logic       pin_sync;
  logic [4:0] tick;
  logic [2:0] nbit;
  logic [7:0] shift;
  logic       par_bit;
  wire        at_sample = (tick == 5'h0);

  // only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= pin;
      pin_sync <= pin_meta;
    end
  end

  assign idle = (state == RX_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= RX_IDLE;
      tick            <= 5'h0;
      nbit            <= 3'h0;
      shift           <= 8'h00;
      par_bit         <= 1'b0;
      char_valid      <= 1'b0;
      char_data       <= 8'h00;
      char_frame_err  <= 1'b0;
      char_parity_err <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      tick       <= at_sample ? FULL_BIT : tick - 5'h1;
      if (!enable) begin
        state <= RX_IDLE;
      end else begin
        unique case (state)
          RX_IDLE: begin
            if (!pin_sync) begin
              state <= RX_START;
              tick  <= HALF_BIT;
            end
          end
          RX_START: begin
            if (at_sample) begin
              state <= pin_sync ? RX_IDLE : RX_DATA;
              nbit  <= 3'h0;
            end
          end
          RX_DATA: begin
            if (at_sample) begin
              shift <= {pin_sync, shift[7:1]};
              nbit  <= nbit + 3'h1;
              if (nbit == 3'h7) begin
                state <= parity_on ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (at_sample) begin
              par_bit <= pin_sync;
              state   <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (at_sample) begin
              state           <= RX_IDLE;
              char_valid      <= 1'b1;
              char_data       <= shift;
              char_frame_err  <= !pin_sync;
              char_parity_err <= parity_on && ((^shift) != par_bit);
            end
          end
        endcase
      end
    end
  end
endmodule : rx_engine

// [uart_status_control.sv]
/*
  status and control part of an asynchronous serial port: register port,
  transmitter with buffer, break and infrared encoding, receive status.
  assumes a register master on clk and an asynchronous serial input pin.
*/
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// What this block does
// R1 - address detect on while its enable bit set
// R2 - match field is the compared address character
// R3 - transmit request follows selected buffer condition
// R4 - plain output idles at inverse of polarity bit
// R5 - encoded output idles at the polarity bit
// R6 - receiver enable gates use of input pin
// R7 - break is start, twelve zeros, stop; self-clears
// R8 - transmit enable drives output; clearing flushes buffer
// R9 - buffer full flag reads buffer state
// R10 - shift empty needs shifter and buffer empty
// R11 - upper unused bits read zero, ignore writes
// R12 - low byte holds receive control and status
// R13 - engines act only with module on, mode set
module uart_status_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // serial line
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_en,
  // request levels
  output logic             tx_irq_req,
  output logic             rx_irq_req
);
  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

  localparam logic [4:0] FULL_BIT = 5'(uart_sc_pkg::BIT_CYCLES - 1);
  localparam logic [4:0] IR_LAST  = 5'(uart_sc_pkg::IR_PULSE_CYCLES);

  // ------------------------------------------------------------
  // control and status storage
  // ------------------------------------------------------------
  logic       addr_detect_enable;
  logic [7:0] match_char;
  logic [1:0] tx_irq_select;
  logic       tx_polarity_invert;
  logic       rx_enable_bit;
  logic       send_break;
  logic       tx_enable_bit;
  logic [1:0] rx_irq_select;
  logic       address_char_enable;
  logic       parity_error;
  logic       framing_error;
  logic       overrun_error;
  logic       rx_data_available;
  logic [7:0] rx_hold;
  logic       module_on;
  logic       infrared_enable;
  logic       parity_on;
  logic       addressed;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_status = reg_write && (reg_addr == uart_sc_pkg::OFF_STATUS);
  wire wr_mode   = reg_write && (reg_addr == uart_sc_pkg::OFF_MODE);
  wire wr_txdata = reg_write && (reg_addr == uart_sc_pkg::OFF_TX_DATA);
  wire rd_rxdata = reg_read && (reg_addr == uart_sc_pkg::OFF_RX_DATA);

  wire tx_active = module_on && tx_enable_bit;   // see R8 see R13
  wire rx_active = module_on && rx_enable_bit;   // see R6 see R13

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  tx_state_t  tx_state;
  logic [7:0] tx_shift;
  logic [4:0] tx_tick;
  logic [3:0] tx_nbit;
  logic       tx_par;
  logic       break_active;
  logic       tx_pop;
  logic [7:0] fifo_data;
  logic       fifo_full;
  logic       fifo_empty;

  tx_buffer u_tx_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (!tx_active),                     // see R8
    .push      (wr_txdata && tx_active),
    .push_data (reg_wdata[7:0]),
    .pop       (tx_pop),
    .pop_data  (fifo_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  wire tx_buffer_full = fifo_full;                         // see R9
  wire tx_shift_empty = fifo_empty && (tx_state == TX_IDLE); // see R10
  wire bit_end        = (tx_tick == 5'h0);
  wire start_break    = tx_active && (tx_state == TX_IDLE) && send_break;
  wire break_done     = break_active && (tx_state == TX_STOP) && bit_end;
  assign tx_pop       = tx_active && (tx_state == TX_IDLE) && !send_break && !fifo_empty;

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state     <= TX_IDLE;
      tx_shift     <= 8'h00;
      tx_tick      <= 5'h0;
      tx_nbit      <= 4'h0;
      tx_par       <= 1'b0;
      break_active <= 1'b0;
    end else if (!tx_active) begin
      tx_state     <= TX_IDLE;                   // see R8
      break_active <= 1'b0;
    end else begin
      tx_tick <= bit_end ? FULL_BIT : tx_tick - 5'h1;
      unique case (tx_state)
        TX_IDLE: begin
          if (start_break) begin
            tx_state     <= TX_START;            // see R7
            break_active <= 1'b1;
            tx_tick      <= FULL_BIT;
          end else if (tx_pop) begin
            tx_state <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tx_shift <= fifo_data;
          tx_par   <= ^fifo_data;
          tx_state <= TX_START;
          tx_tick  <= FULL_BIT;
        end
        TX_START: begin
          if (bit_end) begin
            tx_state <= TX_DATA;
            tx_nbit  <= 4'h0;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_nbit  <= tx_nbit + 4'h1;
            if (break_active && tx_nbit == 4'(uart_sc_pkg::BREAK_ZEROS - 1)) begin
              tx_state <= TX_STOP;               // see R7
            end else if (!break_active && tx_nbit == 4'(uart_sc_pkg::CHAR_BITS - 1)) begin
              tx_state <= parity_on ? TX_PARITY : TX_STOP;
            end
          end
        end
        TX_PARITY: begin
          if (bit_end) begin
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            tx_state     <= TX_IDLE;
            break_active <= 1'b0;
          end
        end
      endcase
    end
  end

  // raw line level before polarity and encoding
  logic tx_level;
  always_comb begin
    unique case (tx_state)
      TX_START:  tx_level = 1'b0;
      TX_DATA:   tx_level = break_active ? 1'b0 : tx_shift[0];
      TX_PARITY: tx_level = tx_par;
      default:   tx_level = 1'b1;
    endcase
  end

  // encoded mode: a zero bit is a short pulse at the start of its period
  wire ir_pulse  = !tx_level && (tx_tick > FULL_BIT - IR_LAST);
  wire plain_out = tx_level ^ tx_polarity_invert;                       // see R4
  wire ir_out    = ir_pulse ? !tx_polarity_invert : tx_polarity_invert; // see R5
  wire next_out  = infrared_enable ? ir_out : plain_out;

  // ------------------------------------------------------------
  // receiver and address filter
  // ------------------------------------------------------------
  logic       rx_valid;
  logic [7:0] rx_char;
  logic       rx_framing_error;
  logic       rx_parity_error;
  logic       receiver_idle;

  rx_engine u_rx_engine (
    .clk             (clk),
    .rst_n           (rst_n),
    .enable          (rx_active),                // see R6
    .parity_on       (parity_on),
    .pin             (serial_in_pin),
    .char_valid      (rx_valid),
    .char_data       (rx_char),
    .char_frame_err  (rx_framing_error),
    .char_parity_err (rx_parity_error),
    .idle            (receiver_idle)
  );

  wire is_match  = (rx_char == match_char);                        // see R2
  wire rx_accept = rx_valid && (!addr_detect_enable || addressed || is_match); // see R1
  wire rx_store  = rx_accept && !rx_data_available;
  wire rx_ovf    = rx_accept && rx_data_available;

  // ------------------------------------------------------------
  // register writes and hardware flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_detect_enable  <= 1'b0;
      match_char          <= 8'h00;
      tx_irq_select       <= 2'h0;
      tx_polarity_invert  <= 1'b0;
      rx_enable_bit       <= 1'b0;
      tx_enable_bit       <= 1'b0;
      rx_irq_select       <= 2'h0;
      address_char_enable <= 1'b0;
      module_on           <= 1'b0;
      infrared_enable     <= 1'b0;
      parity_on           <= 1'b0;
    end else begin
      if (wr_status) begin
        addr_detect_enable  <= reg_wdata[uart_sc_pkg::POS_ADDR_DETECT_ENABLE];   // see R1 see R11
        match_char          <= reg_wdata[uart_sc_pkg::POS_MATCH_LO +: 8];
        tx_irq_select       <= reg_wdata[uart_sc_pkg::POS_TXISEL_LO +: 2];
        tx_polarity_invert  <= reg_wdata[uart_sc_pkg::POS_TX_INV];
        rx_enable_bit       <= reg_wdata[uart_sc_pkg::POS_RX_EN];
        tx_enable_bit       <= reg_wdata[uart_sc_pkg::POS_TX_EN];
        rx_irq_select       <= reg_wdata[uart_sc_pkg::POS_RXISEL_LO +: 2]; // see R12
        address_char_enable <= reg_wdata[uart_sc_pkg::POS_ADDR_CHAR];
      end
      if (wr_mode) begin
        module_on       <= reg_wdata[uart_sc_pkg::POS_MODE_ON];      // see R13
        infrared_enable <= reg_wdata[uart_sc_pkg::POS_MODE_IR];
        parity_on       <= reg_wdata[uart_sc_pkg::POS_MODE_PARITY];
      end
    end
  end

  // hardware set beats software clear on the overrun and data flags; a status write beats the break self-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      send_break        <= 1'b0;
      overrun_error     <= 1'b0;
      rx_data_available <= 1'b0;
      rx_hold           <= 8'h00;
      parity_error      <= 1'b0;
      framing_error     <= 1'b0;
      addressed         <= 1'b0;
    end else begin
      if (wr_status) begin
        send_break <= reg_wdata[uart_sc_pkg::POS_BREAK];
      end else if (break_done) begin
        send_break <= 1'b0;                       // see R7
      end
      if (rx_ovf) begin
        overrun_error <= 1'b1;                    // see R12
      end else if (wr_status) begin
        overrun_error <= reg_wdata[uart_sc_pkg::POS_OVERRUN];
      end
      if (rx_store) begin
        rx_data_available <= 1'b1;
        rx_hold           <= rx_char;
        parity_error      <= rx_parity_error;
        framing_error     <= rx_framing_error;
      end else if (rd_rxdata) begin
        rx_data_available <= 1'b0;
      end
      if (!addr_detect_enable) begin
        addressed <= 1'b0;
      end else if (rx_valid && is_match) begin
        addressed <= 1'b1;                        // see R1 see R2
      end
    end
  end

  // ------------------------------------------------------------
  // read mux and registered outputs
  // ------------------------------------------------------------
  wire [31:0] status_word = {7'h00, addr_detect_enable, match_char,   // see R11
                             tx_irq_select, tx_polarity_invert, rx_enable_bit,
                             send_break, tx_enable_bit, tx_buffer_full, tx_shift_empty,
                             rx_irq_select, address_char_enable, receiver_idle,
                             parity_error, framing_error, overrun_error, rx_data_available};
  wire [31:0] mode_word   = {16'h0000, module_on, 2'h0, infrared_enable, 10'h000, parity_on, 1'b0};
  wire [31:0] rd_word     = (reg_addr == uart_sc_pkg::OFF_STATUS)  ? status_word :
                            (reg_addr == uart_sc_pkg::OFF_MODE)    ? mode_word :
                            (reg_addr == uart_sc_pkg::OFF_RX_DATA) ? {24'h000000, rx_hold} :
                            32'h00000000;

  // transmit request; code 11 never asserts
  wire next_tx_irq = (tx_irq_select == uart_sc_pkg::TXI_NOT_FULL) ? !tx_buffer_full : // see R3
                     (tx_irq_select == uart_sc_pkg::TXI_ALL_SENT) ? tx_shift_empty :
                     (tx_irq_select == uart_sc_pkg::TXI_EMPTY)    ? fifo_empty : 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata      <= 32'h00000000;
      serial_out_pin <= 1'b1;
      serial_out_en  <= 1'b0;
      tx_irq_req     <= 1'b0;
      rx_irq_req     <= 1'b0;
    end else begin
      reg_rdata      <= reg_read ? rd_word : 32'h00000000;
      serial_out_pin <= next_out;
      serial_out_en  <= tx_active;                // see R8
      tx_irq_req     <= tx_active && next_tx_irq;
      rx_irq_req     <= rx_data_available;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence idle_break_s;
    start_break;
  endsequence
  sequence break_frame_s;
    break_active && tx_state == TX_START;
  endsequence

  a_break_starts: assert property (idle_break_s |=> break_frame_s) // see R7
    else $error("break did not start");
  a_break_clears: assert property (break_done && !wr_status |=> !send_break) // see R7
    else $error("send_break not cleared after break");
  a_txen_flush: assert property (!tx_active |=> fifo_empty && tx_state == TX_IDLE) // see R8
    else $error("transmitter not reset when disabled");
  a_plain_idle: assert property (tx_state == TX_IDLE && !infrared_enable
                                 |=> serial_out_pin == !$past(tx_polarity_invert)) // see R4
    else $error("plain idle level wrong");
  a_ir_idle: assert property (tx_state == TX_IDLE && infrared_enable
                              |=> serial_out_pin == $past(tx_polarity_invert)) // see R5
    else $error("encoded idle level wrong");
  a_rx_ignored: assert property (!rx_active [*2] |-> !rx_valid && receiver_idle) // see R6
    else $error("receiver active while disabled");
  a_upper_zero: assert property (reg_read && reg_addr == uart_sc_pkg::OFF_STATUS
                                 |=> reg_rdata[31:25] == 7'h00) // see R11
    else $error("unused status bits not zero");
  a_full_flag: assert property (reg_read && reg_addr == uart_sc_pkg::OFF_STATUS
                                |=> reg_rdata[uart_sc_pkg::POS_TX_FULL] == $past(fifo_full)) // see R9
    else $error("buffer full flag wrong");
  a_shift_empty: assert property (reg_read && reg_addr == uart_sc_pkg::OFF_STATUS
                                  |=> reg_rdata[uart_sc_pkg::POS_SHIFT_EMPTY]
                                      == $past(fifo_empty && tx_state == TX_IDLE)) // see R10
    else $error("shift empty with work pending");
  a_irq_empty: assert property (tx_active && tx_irq_select == uart_sc_pkg::TXI_EMPTY
                                |=> tx_irq_req == $past(fifo_empty)) // see R3
    else $error("transmit request mode 10 wrong");
  a_addr_filter: assert property (addr_detect_enable && !addressed && rx_valid && !is_match
                                  && !rd_rxdata |=> $stable(rx_data_available)) // see R1
    else $error("unaddressed character accepted");
endmodule : uart_status_control

// [serial_peer.sv]
/*
  remote serial device: sends characters on the line into the block.
  assumes 8 data bits, no parity, one stop bit, bit period of the package.
*/
`timescale 1ns/1ns
module serial_peer (
  // clock
  input  wire logic clk,
  // line
  output logic      line
);
  // line idles high between frames, so the receiver never sees a false start
  initial line = 1'b1;
  task automatic send(input logic [7:0] ch);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= fr[i];
      repeat (uart_sc_pkg::BIT_CYCLES) @(posedge clk);
    end
  endtask : send
endmodule : serial_peer

// [uart_status_control_tb.sv]
/*
  self-checking bench for the serial port status and control block.
  assumes the register map and bit timing of the package.
*/
`timescale 1ns/1ns
module uart_status_control_tb;
  logic        clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        line, serial_out_pin, serial_out_en, tx_irq_req, rx_irq_req;
  int          err_total = 0, compares = 0;
  always #2 clk = ~clk;
  serial_peer i_peer (.clk(clk), .line(line));
  uart_status_control i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .serial_in_pin(line), .serial_out_pin(serial_out_pin),
    .serial_out_en(serial_out_en), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req));
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // waits for a start edge, then samples each bit at its middle
  task automatic frame(input logic [13:0] bits, input int n);
    int k = 0;
    while (serial_out_pin === 1'b1 && k < 60) begin
      @(posedge clk); #1 k++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      #1 chk("line bit", serial_out_pin, bits[i]);
      repeat (uart_sc_pkg::BIT_CYCLES) @(posedge clk);
    end
  endtask : frame
  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(4'h0); chk("status reset", d, 32'h0000_0110);
    wr(4'h0, 32'hFFFF_C0E2);
    rd(4'h0); chk("status fields", d, 32'h01FF_C1F2);
    wr(4'h0, 32'h0); rd(4'h0); chk("status clear", d, 32'h0000_0110);
    $display("test regs done");
  endtask : t_regs
  task automatic t_tx;
    wr(4'h4, 32'h0000_8000); wr(4'h0, 32'h0000_0400);
    @(posedge clk); #1 chk("out en", serial_out_en, 1'b1);
    chk("idle plain", serial_out_pin, 1'b1);
    wr(4'h8, 32'h35); frame({4'h0, 1'b1, 8'h35, 1'b0}, 10);
    // even parity on: three ones in the data make the parity bit one
    wr(4'h4, 32'h0000_8002); wr(4'h8, 32'h34);
    frame({3'h0, 2'h3, 8'h34, 1'b0}, 11);
    wr(4'h0, 32'h0000_0C00); frame(14'h2000, 14);
    repeat (20) @(posedge clk);
    rd(4'h0); chk("break cleared", d[11], 1'b0);
    for (int i = 0; i < 5; i++) wr(4'h8, 32'h41 + i);
    rd(4'h0); chk("full", d[9:8], 2'h2);
    wr(4'h0, 32'h0); rd(4'h0); chk("flushed", d, 32'h0000_0110);
    #1 chk("out off", serial_out_en, 1'b0);
    $display("test tx done");
  endtask : t_tx
  task automatic t_modes;
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, (s << 14) | 32'h400); repeat (2) @(posedge clk);
      #1 chk("tx req", tx_irq_req, s != 3);
    end
    // one character shifting, then one waiting, tells codes 01 and 10 apart
    wr(4'h0, 32'h4400); wr(4'h8, 32'h55); repeat (2) @(posedge clk);
    #1 chk("req all sent", tx_irq_req, 1'b0);
    wr(4'h0, 32'h8400); repeat (2) @(posedge clk);
    #1 chk("req empty", tx_irq_req, 1'b1);
    wr(4'h8, 32'h66); repeat (2) @(posedge clk);
    #1 chk("req not empty", tx_irq_req, 1'b0);
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h2400); repeat (2) @(posedge clk);
    #1 chk("idle inv", serial_out_pin, 1'b0);
    wr(4'h4, 32'h9000); repeat (2) @(posedge clk);
    #1 chk("ir idle inv", serial_out_pin, 1'b1);
    wr(4'h0, 32'h0400); repeat (2) @(posedge clk);
    #1 chk("ir idle", serial_out_pin, 1'b0);
    wr(4'h4, 32'h8000); wr(4'h0, 32'h1000);
    i_peer.send(8'hA5); repeat (4) @(posedge clk);
    rd(4'h0); chk("avail", d[0], 1'b1);
    chk("rx req", rx_irq_req, 1'b1);
    rd(4'hC); chk("rx data", d[7:0], 8'hA5);
    wr(4'h0, 32'h0); i_peer.send(8'h5A); repeat (4) @(posedge clk);
    rd(4'h0); chk("rx ignored", d[0], 1'b0);
    chk("rx req off", rx_irq_req, 1'b0);
    wr(4'h0, 32'h013C_1000); i_peer.send(8'h5A); repeat (4) @(posedge clk);
    rd(4'h0); chk("no match", d[0], 1'b0);
    i_peer.send(8'h3C); repeat (4) @(posedge clk);
    rd(4'hC); chk("match", d[7:0], 8'h3C);
    $display("test modes done");
  endtask : t_modes
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs; t_tx; t_modes;
    report_and_stop;
  end
  // long waits above are bounded; this cuts a hang in the design
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
endmodule : uart_status_control_tb
